// ===== core/bfs_pkg.sv
package bfs_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STEP_MS = 10;
  localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned DETACH_HOLD_MS = 2;
  localparam int unsigned DETACH_HOLD_CYCLES = CLK_HZ / 1000 * DETACH_HOLD_MS;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_TA_LO = 16'h413C;
  localparam logic [15:0] IDX_TA_HI = 16'h413D;
  localparam logic [15:0] IDX_TB_LO = 16'h413E;
  localparam logic [15:0] IDX_TB_HI = 16'h413F;
  localparam logic [15:0] IDX_CTRL = 16'h4140;
  localparam logic [15:0] IDX_STAT = 16'h4141;

  // Reset values
  localparam logic [7:0] RST_TA_LO = 8'hD0;
  localparam logic [7:0] RST_TA_HI = 8'h07;
  localparam logic [7:0] RST_TB_LO = 8'hD0;
  localparam logic [7:0] RST_TB_HI = 8'h07;
  localparam logic [7:0] RST_CTRL = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB = 1;
  localparam int unsigned CTRL_SEL_MSB = 5;
  localparam int unsigned CTRL_USED_MSB = 5;
  localparam logic [4:0] SEL_RESERVED = 5'h09;
  localparam logic [4:0] SEL_MAX = 5'h10;
  localparam int unsigned NUM_PINS = 16;

  // Descriptor constants
  localparam logic [1:0] BM_CONFIG_UNSPEC = 2'h0;
  localparam logic [15:0] BB_BCD_VERSION = 16'h0110;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_DETACH_BB = 2'b01,
    ST_BILLBOARD = 2'b10,
    ST_DETACH_NRM = 2'b11
  } bfs_state_e;

endpackage

// ===== core/bfs_detach_timer.sv
`timescale 1ns/1ps
module bfs_detach_timer #(
  parameter int unsigned STEP_CYCLES = bfs_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] timeout,
  // Status
  output logic running,
  output logic expire
);

  localparam int unsigned PW = $clog2(STEP_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(STEP_CYCLES - 1);

  logic running_reg, running_next;
  logic expire_reg, expire_next;
  logic [15:0] count_reg, count_next;
  logic [PW-1:0] presc_reg, presc_next;

  // Countdown in 10 ms steps; timeout snapshot taken at start
  always_comb begin
    running_next = running_reg;
    expire_next = 1'b0;
    count_next = count_reg;
    presc_next = presc_reg;
    if (stop) begin
      running_next = 1'b0;
    end else if (start) begin
      running_next = 1'b1; // RL13
      count_next = timeout;
      presc_next = '0;
    end else if (running_reg) begin
      if (presc_reg == PRESC_LAST) begin
        presc_next = '0;
        if (count_reg <= 16'h0001) begin
          running_next = 1'b0;
          expire_next = 1'b1;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else begin
        presc_next = presc_reg + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running_reg <= 1'b0;
      expire_reg <= 1'b0;
      count_reg <= 16'h0000;
      presc_reg <= '0;
    end else begin
      running_reg <= running_next;
      expire_reg <= expire_next;
      count_reg <= count_next;
      presc_reg <= presc_next;
    end
  end

  assign running = running_reg;
  assign expire = expire_reg;

  chk_start_loads_timeout: assert property (@(posedge clk) disable iff (!arst_n) // RL13
    start && !stop |=> running_reg && count_reg == $past(timeout) && presc_reg == '0)
    else $error("timer did not load timeout on start");

  chk_expire_on_step: assert property (@(posedge clk) disable iff (!arst_n) // RL13
    expire_reg |-> $past(running_reg) && $past(presc_reg) == PRESC_LAST && !running_reg)
    else $error("timer expired off a step boundary");

endmodule

// ===== core/bfs_sequencer.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// RL1: Control bits 5:1 pick the failure input pin, reset code 01010.
// RL2: Codes 0-8 and 10-16 map to pins; code 9 selects nothing.
// RL3: Control bit 0 enables the failover feature.
// RL4: Outside controller holds the selected input low only on negotiation failure.
// RL5: Enabled and selected input low starts the detach and re-attach sequence.
// RL6: First step disconnects the internal device from its hub port.
// RL7: Reconnect with failover class descriptors, class version 1.1.
// RL8: Host address assignment starts the first detach timer.
// RL9: Failover shown only on failure; configured field reports 00 by default.
// RL10: Alternate-mode string request is answered and starts the second timer.
// RL11: Either timer expiring disconnects the internal device again.
// RL12: Afterwards reconnect with normal descriptors and function.
// RL13: Each timer loads a 16-bit low/high byte timeout in 10 ms steps.
// RL14: First timer resets to 07D0h steps, twenty seconds.
// RL15: Second timer also defaults to twenty seconds.
// RL16: Failure message content comes from the one-time-programmable store.
// RL17: With enable low the input is ignored and normal mode kept.
module bfs_sequencer #(
  parameter int unsigned STEP_CYCLES = bfs_pkg::STEP_CYCLES,
  parameter int unsigned DETACH_CYCLES = bfs_pkg::DETACH_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Failure indication pins, active low
  input wire logic [bfs_pkg::NUM_PINS-1:0] general_purpose_pin,
  // Internal device events
  input wire logic addr_set,
  input wire logic alt_string_req,
  // Internal device control
  output logic port_connect,
  output logic billboard_desc,
  output logic otp_msg_sel,
  output logic alt_string_ack,
  output logic [1:0] bm_configured,
  output logic [15:0] bcd_version
);

  localparam int unsigned DW = $clog2(DETACH_CYCLES + 1);
  localparam logic [DW-1:0] DETACH_LAST = DW'(DETACH_CYCLES - 1);

  // Byte address of a register index
  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    byte_addr = {14'h0000, idx, 2'b00};
  endfunction

  // Select code valid and mapped pin index
  function automatic logic sel_valid(input logic [4:0] code);
    sel_valid = (code != bfs_pkg::SEL_RESERVED) && (code <= bfs_pkg::SEL_MAX);
  endfunction

  function automatic logic [3:0] sel_index(input logic [4:0] code);
    if (code < bfs_pkg::SEL_RESERVED) begin
      sel_index = code[3:0];
    end else begin
      sel_index = 4'(code - 5'h01);
    end
  endfunction

  // Bus data phase state
  logic dp_wr_reg, dp_wr_next;
  logic dp_rd_reg, dp_rd_next;
  logic [31:0] dp_addr_reg, dp_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hready_reg, hready_next;

  // Register file
  logic [7:0] ta_lo_reg, ta_lo_next;
  logic [7:0] ta_hi_reg, ta_hi_next;
  logic [7:0] tb_lo_reg, tb_lo_next;
  logic [7:0] tb_hi_reg, tb_hi_next;
  logic [5:0] ctrl_reg, ctrl_next;

  // Sequencer
  bfs_pkg::bfs_state_e state_reg, state_next;
  logic [DW-1:0] hold_reg, hold_next;
  logic rearm_reg, rearm_next;
  logic connect_reg, connect_next;
  logic bb_desc_reg, bb_desc_next;
  logic ack_reg, ack_next;

  logic addr_ok;
  logic fail_low;
  logic enabled;
  logic [4:0] sel_code;
  logic ta_start, tb_start, timers_stop;
  logic ta_run, tb_run, ta_exp, tb_exp;
  logic [31:0] stat_word;

  assign addr_ok = hsel && hready && htrans[1] && hready_reg;
  assign enabled = ctrl_reg[bfs_pkg::CTRL_EN_BIT]; // RL3
  assign sel_code = ctrl_reg[bfs_pkg::CTRL_SEL_MSB:bfs_pkg::CTRL_SEL_LSB]; // RL1
  // Reserved or out-of-range code reads as idle high
  assign fail_low = sel_valid(sel_code) && !general_purpose_pin[sel_index(sel_code)]; // RL2 RL4
  assign stat_word = {24'h000000, tb_run, ta_run, rearm_reg, fail_low, bb_desc_reg, connect_reg, state_reg};

  // Address phase capture; reads take one wait state so a preceding write is visible
  always_comb begin
    dp_wr_next = addr_ok && hwrite;
    dp_rd_next = addr_ok && !hwrite;
    dp_addr_next = addr_ok ? haddr : dp_addr_reg;
    hready_next = !(addr_ok && !hwrite);
    hrdata_next = hrdata_reg;
    if (dp_rd_reg) begin
      unique case (dp_addr_reg)
        byte_addr(bfs_pkg::IDX_TA_LO): hrdata_next = {24'h000000, ta_lo_reg};
        byte_addr(bfs_pkg::IDX_TA_HI): hrdata_next = {24'h000000, ta_hi_reg};
        byte_addr(bfs_pkg::IDX_TB_LO): hrdata_next = {24'h000000, tb_lo_reg};
        byte_addr(bfs_pkg::IDX_TB_HI): hrdata_next = {24'h000000, tb_hi_reg};
        byte_addr(bfs_pkg::IDX_CTRL): hrdata_next = {26'h0000000, ctrl_reg};
        byte_addr(bfs_pkg::IDX_STAT): hrdata_next = stat_word;
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_addr_reg <= 32'h00000000;
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b1;
    end else begin
      dp_wr_reg <= dp_wr_next;
      dp_rd_reg <= dp_rd_next;
      dp_addr_reg <= dp_addr_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
    end
  end

  // Register writes in the data phase; unmapped addresses are ignored
  always_comb begin
    ta_lo_next = ta_lo_reg;
    ta_hi_next = ta_hi_reg;
    tb_lo_next = tb_lo_reg;
    tb_hi_next = tb_hi_reg;
    ctrl_next = ctrl_reg;
    if (dp_wr_reg) begin
      unique case (dp_addr_reg)
        byte_addr(bfs_pkg::IDX_TA_LO): ta_lo_next = hwdata[7:0]; // RL13
        byte_addr(bfs_pkg::IDX_TA_HI): ta_hi_next = hwdata[7:0];
        byte_addr(bfs_pkg::IDX_TB_LO): tb_lo_next = hwdata[7:0];
        byte_addr(bfs_pkg::IDX_TB_HI): tb_hi_next = hwdata[7:0];
        byte_addr(bfs_pkg::IDX_CTRL): ctrl_next = hwdata[bfs_pkg::CTRL_USED_MSB:0]; // RL1 RL3
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // Reset values give 20 s on both timers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ta_lo_reg <= bfs_pkg::RST_TA_LO; // RL14
      ta_hi_reg <= bfs_pkg::RST_TA_HI; // RL14
      tb_lo_reg <= bfs_pkg::RST_TB_LO; // RL15
      tb_hi_reg <= bfs_pkg::RST_TB_HI; // RL15
      ctrl_reg <= bfs_pkg::RST_CTRL[bfs_pkg::CTRL_USED_MSB:0];
    end else begin
      ta_lo_reg <= ta_lo_next;
      ta_hi_reg <= ta_hi_next;
      tb_lo_reg <= tb_lo_next;
      tb_hi_reg <= tb_hi_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Timers only run while the failover device is attached
  assign ta_start = (state_reg == bfs_pkg::ST_BILLBOARD) && addr_set; // RL8
  assign tb_start = (state_reg == bfs_pkg::ST_BILLBOARD) && alt_string_req; // RL10
  assign timers_stop = (state_reg != bfs_pkg::ST_BILLBOARD);

  bfs_detach_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer_a (
    .clk(clk),
    .arst_n(arst_n),
    .start(ta_start),
    .stop(timers_stop),
    .timeout({ta_hi_reg, ta_lo_reg}),
    .running(ta_run),
    .expire(ta_exp)
  );

  bfs_detach_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer_b (
    .clk(clk),
    .arst_n(arst_n),
    .start(tb_start),
    .stop(timers_stop),
    .timeout({tb_hi_reg, tb_lo_reg}),
    .running(tb_run),
    .expire(tb_exp)
  );

  // Failover sequence; rearm stops a held-low input from looping the sequence
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    rearm_next = rearm_reg || !fail_low || !enabled;
    ack_next = 1'b0;
    unique case (state_reg)
      bfs_pkg::ST_NORMAL: begin
        if (enabled && fail_low && rearm_reg) begin // RL5 RL17
          state_next = bfs_pkg::ST_DETACH_BB; // RL6
          hold_next = '0;
          rearm_next = 1'b0;
        end
      end
      bfs_pkg::ST_DETACH_BB: begin
        if (hold_reg == DETACH_LAST) begin
          state_next = bfs_pkg::ST_BILLBOARD; // RL7
        end else begin
          hold_next = hold_reg + DW'(1);
        end
      end
      bfs_pkg::ST_BILLBOARD: begin
        ack_next = alt_string_req; // RL10
        if (ta_exp || tb_exp || !enabled) begin // RL11 RL17
          state_next = bfs_pkg::ST_DETACH_NRM;
          hold_next = '0;
        end
      end
      bfs_pkg::ST_DETACH_NRM: begin
        if (hold_reg == DETACH_LAST) begin
          state_next = bfs_pkg::ST_NORMAL; // RL12
        end else begin
          hold_next = hold_reg + DW'(1);
        end
      end
    endcase
    connect_next = (state_next == bfs_pkg::ST_NORMAL) || (state_next == bfs_pkg::ST_BILLBOARD); // RL6 RL11
    bb_desc_next = (state_next == bfs_pkg::ST_BILLBOARD); // RL7 RL9 RL16
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= bfs_pkg::ST_NORMAL;
      hold_reg <= '0;
      rearm_reg <= 1'b0;
      connect_reg <= 1'b1;
      bb_desc_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      rearm_reg <= rearm_next;
      connect_reg <= connect_next;
      bb_desc_reg <= bb_desc_next;
      ack_reg <= ack_next;
    end
  end

  // Constant descriptor fields and bus response, still flop-driven
  logic [1:0] bm_cfg_reg;
  logic [15:0] bcd_reg;
  logic hresp_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bm_cfg_reg <= bfs_pkg::BM_CONFIG_UNSPEC; // RL9
      bcd_reg <= bfs_pkg::BB_BCD_VERSION; // RL7
      hresp_reg <= 1'b0;
    end else begin
      bm_cfg_reg <= bfs_pkg::BM_CONFIG_UNSPEC;
      bcd_reg <= bfs_pkg::BB_BCD_VERSION;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;
  assign port_connect = connect_reg;
  assign billboard_desc = bb_desc_reg;
  assign otp_msg_sel = bb_desc_reg;
  assign alt_string_ack = ack_reg;
  assign bm_configured = bm_cfg_reg;
  assign bcd_version = bcd_reg;

  chk_fail_entry: assert property (@(posedge clk) disable iff (!arst_n) // RL5
    state_reg == bfs_pkg::ST_NORMAL && enabled && fail_low && rearm_reg |=> state_reg == bfs_pkg::ST_DETACH_BB)
    else $error("failure input did not start detach");

  chk_disabled_normal: assert property (@(posedge clk) disable iff (!arst_n) // RL17
    state_reg == bfs_pkg::ST_NORMAL && !enabled |=> state_reg == bfs_pkg::ST_NORMAL)
    else $error("sequence started while disabled");

  chk_reserved_code: assert property (@(posedge clk) disable iff (!arst_n) // RL2
    state_reg == bfs_pkg::ST_NORMAL && sel_code == bfs_pkg::SEL_RESERVED |=> state_reg == bfs_pkg::ST_NORMAL)
    else $error("reserved select code started sequence");

  chk_detach_port: assert property (@(posedge clk) disable iff (!arst_n) // RL6
    connect_reg == (state_reg == bfs_pkg::ST_NORMAL || state_reg == bfs_pkg::ST_BILLBOARD))
    else $error("port connect does not follow state");

  chk_bb_reattach: assert property (@(posedge clk) disable iff (!arst_n) // RL7
    state_reg == bfs_pkg::ST_DETACH_BB && hold_reg == DETACH_LAST |=> connect_reg && bb_desc_reg)
    else $error("no reattach with failover descriptors");

  chk_timer_a_start: assert property (@(posedge clk) disable iff (!arst_n) // RL8
    state_reg == bfs_pkg::ST_BILLBOARD && addr_set && enabled && !ta_exp && !tb_exp |=> ta_run)
    else $error("address assignment did not start timer a");

  chk_string_ack: assert property (@(posedge clk) disable iff (!arst_n) // RL10
    state_reg == bfs_pkg::ST_BILLBOARD && alt_string_req |=> alt_string_ack ##1 !alt_string_ack || alt_string_req)
    else $error("string request not answered");

  chk_expire_detach: assert property (@(posedge clk) disable iff (!arst_n) // RL11
    state_reg == bfs_pkg::ST_BILLBOARD && (ta_exp || tb_exp) |=> !connect_reg && !bb_desc_reg)
    else $error("timer expiry did not detach");

  chk_normal_return: assert property (@(posedge clk) disable iff (!arst_n) // RL12
    state_reg == bfs_pkg::ST_DETACH_NRM && hold_reg == DETACH_LAST |=> connect_reg && !bb_desc_reg)
    else $error("no reattach with normal descriptors");

  chk_read_wait: assert property (@(posedge clk) disable iff (!arst_n)
    addr_ok && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule

// ===== testbench/bfs_far_end.sv
`timescale 1ns/1ps
// Far side: outside controller pins plus host events
module bfs_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Commands from the bench, plus the string answer from the sequencer
  input wire logic fail_on,
  input wire logic [3:0] fail_pin,
  input wire logic [15:0] noise,
  input wire logic host_addr,
  input wire logic host_str,
  input wire logic alt_string_ack,
  // Toward the sequencer, plus the answer count toward the bench
  output logic [15:0] general_purpose_pin,
  output logic addr_set,
  output logic alt_string_req,
  output int ack_count
);
  // Failure pin low only while failing; other pins carry noise, so a wrong select shows up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      general_purpose_pin <= 16'hFFFF;
      addr_set <= 1'b0;
      alt_string_req <= 1'b0;
      ack_count <= 0;
    end else begin
      if (fail_on) begin
        general_purpose_pin <= noise & ~(16'h1 << fail_pin);
      end else begin
        general_purpose_pin <= noise | (16'h1 << fail_pin);
      end
      addr_set <= host_addr;
      alt_string_req <= host_str;
      ack_count <= ack_count + int'(alt_string_ack);
    end
  end
endmodule

// ===== testbench/billboard_failover_sequencer_bench.sv
`timescale 1ns/1ps
module billboard_failover_sequencer_bench;
  localparam int STEP = 4;
  localparam int HOLD = 3;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, port_connect, billboard_desc, otp_msg_sel, alt_string_ack;
  logic [1:0] bm_configured;
  logic [15:0] bcd_version, pins;
  logic [15:0] noise = 16'hFFFF;
  logic addr_set, alt_string_req;
  logic fail_on = 1'b0;
  logic host_addr = 1'b0;
  logic host_str = 1'b0;
  logic [3:0] fail_pin = 4'h0;
  int miscompares = 0;
  int tests_run = 0;
  int acks;

  // 50 MHz clock
  always #10 clk = ~clk;

  bfs_sequencer #(.STEP_CYCLES(STEP), .DETACH_CYCLES(HOLD)) i_bfs_sequencer (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .general_purpose_pin(pins),
    .addr_set(addr_set), .alt_string_req(alt_string_req), .port_connect(port_connect),
    .billboard_desc(billboard_desc), .otp_msg_sel(otp_msg_sel), .alt_string_ack(alt_string_ack),
    .bm_configured(bm_configured), .bcd_version(bcd_version));

  bfs_far_end i_bfs_far_end (.clk(clk), .arst_n(arst_n), .fail_on(fail_on), .fail_pin(fail_pin),
    .noise(noise), .host_addr(host_addr), .host_str(host_str), .alt_string_ack(alt_string_ack),
    .general_purpose_pin(pins), .addr_set(addr_set), .alt_string_req(alt_string_req), .ack_count(acks));

  // Verdict and end of run
  task stop_test;
    $display("counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare a register word
  task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare a single port level
  task check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task give_up(input string what);
    miscompares++;
    $display("BAD %s expected answer seen timeout", what);
    stop_test();
  endtask

  // One edge at least, then until hready is sampled high
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 40) give_up("hreadyout");
      @(posedge clk);
    end
  endtask

  // Single AHB word transfer; read data taken at the data phase's ready edge
  task bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task wr(input logic [15:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task rd_check(input string what, input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check_word(what, exp, rd);
    check_bit("okay response", 1'b0, hresp);
  endtask

  // Edges until port_connect reaches a level, bounded
  task wait_conn(input logic lvl, input int lim, output int n);
    n = 0;
    while (port_connect !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) give_up("port_connect");
    end
  endtask

  // Pin index that a select code should pick, -1 for none
  function automatic int pin_of(input logic [4:0] code);
    if (code < 5'h09) return int'(code);
    if (code == 5'h09 || code > 5'h10) return -1;
    return int'(code) - 1;
  endfunction

  // Raise a failure on the selected pin; noise on the others must not trigger
  task failover(input logic [4:0] code);
    int n, p;
    p = pin_of(code);
    wr(bfs_pkg::IDX_CTRL, {26'h0, code, 1'b1});
    fail_pin <= p[3:0];
    noise <= 16'($urandom);
    repeat (8) @(posedge clk);
    check_bit("idle connect", 1'b1, port_connect);
    fail_on <= 1'b1;
    if (p < 0) begin
      noise <= 16'h0;
      repeat (12) @(posedge clk);
      check_bit("reserved code", 1'b1, port_connect);
    end else begin
      wait_conn(1'b0, 4, n);
      check_bit("first detach", 1'b0, billboard_desc);
      wait_conn(1'b1, HOLD + 4, n);
      check_bit("hold length", 1'b1, n >= HOLD - 1 && n <= HOLD + 1);
      check_bit("failover desc", 1'b1, billboard_desc);
      check_bit("stored message", 1'b1, otp_msg_sel);
      check_word("class version", 32'h0110, {16'h0, bcd_version});
      check_word("configured", 32'h0, {30'h0, bm_configured});
    end
    fail_on <= 1'b0;
    noise <= 16'hFFFF;
  endtask

  // Second detach then normal attach
  task back_home(input int lim, output int n);
    int m;
    wait_conn(1'b0, lim, n);
    check_bit("leave desc", 1'b0, billboard_desc);
    wait_conn(1'b1, HOLD + 4, m);
    check_bit("normal desc", 1'b0, billboard_desc);
    check_bit("normal message", 1'b0, otp_msg_sel);
  endtask

  // Timer run: program steps, enter failover, fire the start event, time the expiry
  task timed(input logic use_b, input logic [15:0] steps);
    int n, a0;
    wr(use_b ? bfs_pkg::IDX_TB_LO : bfs_pkg::IDX_TA_LO, {24'h0, steps[7:0]});
    wr(use_b ? bfs_pkg::IDX_TB_HI : bfs_pkg::IDX_TA_HI, {24'h0, steps[15:8]});
    failover(5'h0A);
    a0 = acks;
    host_addr <= !use_b;
    host_str <= use_b;
    @(posedge clk);
    host_addr <= 1'b0;
    host_str <= 1'b0;
    back_home(int'(steps) * STEP + 12, n);
    n++;
    check_bit("expiry time", 1'b1, n > int'(steps) * STEP && n <= int'(steps) * STEP + 7);
    check_word("string answers", a0 + use_b, acks);
    $display("test timer %0d steps %0d done", use_b, steps);
  endtask

  // Main sequence
  initial begin
    int n;
    logic [7:0] v;
    void'($urandom(83481));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_check("timer a low", bfs_pkg::IDX_TA_LO, 32'hD0);
    rd_check("timer a high", bfs_pkg::IDX_TA_HI, 32'h07);
    rd_check("timer b low", bfs_pkg::IDX_TB_LO, 32'hD0);
    rd_check("timer b high", bfs_pkg::IDX_TB_HI, 32'h07);
    rd_check("control", bfs_pkg::IDX_CTRL, 32'h14);
    rd_check("status", bfs_pkg::IDX_STAT, 32'h24);
    rd_check("unmapped", 16'h4150, 32'h0);
    check_bit("reset connect", 1'b1, port_connect);
    check_bit("reset desc", 1'b0, billboard_desc);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(bfs_pkg::IDX_TA_LO + 16'(i), {24'hFFFFFF, v});
      rd_check("timer byte", bfs_pkg::IDX_TA_LO + 16'(i), {24'h0, v});
    end
    wr(bfs_pkg::IDX_CTRL, 32'hFF);
    rd_check("control mask", bfs_pkg::IDX_CTRL, 32'h3F);
    wr(16'h4150, 32'hFF);
    rd_check("unmapped write", 16'h4150, 32'h0);
    $display("test registers done");
    wr(bfs_pkg::IDX_CTRL, 32'h14);
    noise <= 16'h0;
    fail_on <= 1'b1;
    host_addr <= 1'b1;
    host_str <= 1'b1;
    @(posedge clk);
    host_addr <= 1'b0;
    host_str <= 1'b0;
    repeat (20) @(posedge clk);
    check_bit("disabled connect", 1'b1, port_connect);
    check_bit("disabled desc", 1'b0, billboard_desc);
    check_word("ignored request", 32'h0, acks);
    fail_on <= 1'b0;
    noise <= 16'hFFFF;
    $display("test disabled done");
    for (int c = 0; c < 17; c++) begin
      failover(5'(c));
      wr(bfs_pkg::IDX_CTRL, {26'h0, 5'(c), 1'b0});
      if (pin_of(5'(c)) >= 0) back_home(12, n);
    end
    $display("test pin select done");
    timed(1'b0, 16'h0001);
    timed(1'b0, 16'(1 + $urandom % 9));
    timed(1'b1, 16'h0102);
    timed(1'b1, 16'(1 + $urandom % 9));
    timed(1'b0, 16'h07D0);
    stop_test();
  end
endmodule
